// ===== mbw_adapter.sv
// Byte-lane mapping and width adaptation from a 32-bit master to a slave port
//
// Behaviour
// - Ports carry descending bit order; bits 7:0 are byte offset 0.
// - Slave lane depends only on byte address, for every master.
// - Wide master to narrow slave: slave-width beats, lowest bytes first.
// - Narrow master to wide slave: bytes realigned to addressed lanes.
// - Master writes naturally aligned byte, halfword, word; a doubleword needs only word alignment.
// - Byte write at offset N enables only lane N.
// - Word write enables all four lanes, LSB on bits 7:0.
// - Least significant byte of a value sits at lowest offset.
// - 64-bit value: LSB at offset 0, MSB at offset 7.
// - 64-bit store goes as one request, sent in slave-width beats, lowest bytes first.
// - Byte and halfword writes address from a four-byte aligned base.
// - Port lane map is independent of internal byte significance.
// - Odd-ordered cores are wrapped to the little-endian lane order.
// - Copy reads run sequentially upward from the source base.
// - Copy writes run sequentially upward from the destination base.
`timescale 1ns/1ps
module mbw_adapter #(
	parameter int SLV_W = 16
) (
	// Clock, reset, enable
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  ce_i,
	// Master request
	input  wire logic                  req_valid_i,
	output logic                       req_ready_o,
	input  wire mbw_pkg::mbw_req_s     req_i,
	output logic                       req_misalign_o,
	// Slave write port
	output logic                       slv_write_o,
	output logic [mbw_pkg::AW-1:0]     slv_addr_o,
	output logic [SLV_W-1:0]           slv_wdata_o,
	output logic [SLV_W/8-1:0]         slv_be_o,
	input  wire logic                  slv_wait_i
);
	localparam int SB    = SLV_W / 8;
	localparam int LB    = (SB > 1) ? $clog2(SB) : 1;
	// Room for a doubleword placed at the top word of the widest slave
	localparam int WBUF  = 256;
	localparam int NBYTE = WBUF / 8;
	localparam int BW    = mbw_pkg::AW + SLV_W + SB;

	// Beat record handed to the two-entry buffer
	typedef struct packed {
		logic [mbw_pkg::AW-1:0] addr;
		logic [SLV_W-1:0]       data;
		logic [SB-1:0]          be;
	} mbw_beat_s;

	// Whole adapter state
	typedef struct packed {
		mbw_pkg::mbw_state_e    state;
		logic                   rdy;
		logic [mbw_pkg::AW-1:0] addr;
		logic [NBYTE-1:0][7:0]  bytes;
		logic [NBYTE-1:0]       ben;
		logic [4:0]             left;
		logic                   misalign;
		logic                   wr;
		logic [mbw_pkg::AW-1:0] oaddr;
		logic [SLV_W-1:0]       odata;
		logic [SB-1:0]          obe;
	} mbw_st_s;

	// Reset image: idle and ready, nothing pending
	localparam mbw_st_s ST_RST = '{state: mbw_pkg::MBW_IDLE, rdy: 1'b1, default: '0};

	mbw_st_s   st_r;
	mbw_st_s   st_nxt;
	mbw_beat_s beat_in;
	mbw_beat_s beat_out;
	logic      buf_in_ready;
	logic      buf_out_valid;
	logic      buf_pop;
	logic      beat_live;

	// Buffer head with disabled lanes cleared
	logic [SLV_W-1:0] lane_data;

	////////////////////////////////////////////////////////////////////////
	// Byte-enable mask of one master access in master lanes

	function automatic logic [7:0] lane_mask(input logic [1:0] sz, input logic [1:0] off);
		logic [7:0] m;
		m = 8'h0;
		case (sz)
			mbw_pkg::SZ_BYTE: m = 8'h1 << off;
			mbw_pkg::SZ_HALF: m = {4'h0, mbw_pkg::BE_HALF} << {off[1], 1'b0};
			mbw_pkg::SZ_WORD: m = {4'h0, mbw_pkg::BE_WORD};
			mbw_pkg::SZ_DWRD: m = 8'hff;
			default:          m = 8'h0;
		endcase
		return m;
	endfunction

	// Alignment check against the access size; doubleword needs only word alignment
	function automatic logic aligned(input logic [1:0] sz, input logic [2:0] a);
		logic ok;
		ok = 1'b0;
		case (sz)
			mbw_pkg::SZ_BYTE: ok = 1'b1;
			mbw_pkg::SZ_HALF: ok = (a[0] == 1'b0);
			mbw_pkg::SZ_WORD: ok = (a[1:0] == 2'h0);
			mbw_pkg::SZ_DWRD: ok = (a[1:0] == 2'h0);
			default:          ok = 1'b0;
		endcase
		return ok;
	endfunction

	// Word position of an access inside the slave word; zero below a word
	function automatic logic [3:0] slave_off(input logic [mbw_pkg::AW-1:0] a);
		logic [3:0] o;
		o = 4'(a[LB-1:0] & 4'(SB - 1)) & 4'hc;
		if (SB < 4) begin
			o = 4'h0;
		end
		return o;
	endfunction

	// Slave beats covering a word or doubleword that starts at lane off
	function automatic logic [4:0] span_beats(input logic [1:0] sz, input logic [3:0] off);
		int n;
		n = (sz == mbw_pkg::SZ_DWRD) ? 8 : 4;
		return 5'((int'(off) + n + SB - 1) / SB);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Request capture and beat generation

	assign req_ready_o = st_r.rdy;

	always_comb begin
		logic [7:0]             m;
		logic [63:0]            val;
		logic [mbw_pkg::AW-1:0] base;
		logic [3:0]             off;
		logic                   pick;
		m    = 8'h0;
		val  = 64'h0;
		base = '0;
		off  = 4'h0;
		pick = 1'b0;
		st_nxt = st_r;
		beat_in = '0;
		case (st_r.state)
			mbw_pkg::MBW_IDLE: begin
				if (req_valid_i) begin
					// Value placed LSB-first onto lanes of its address
					m    = lane_mask(req_i.size, req_i.addr[1:0]);
					val  = req_i.data << {req_i.addr[1:0], 3'h0};
					base = req_i.addr & ~mbw_pkg::AW'(SB - 1);
					st_nxt.misalign = ~aligned(req_i.size, req_i.addr[2:0]);
					if (aligned(req_i.size, req_i.addr[2:0])) begin
						st_nxt.bytes = '0;
						st_nxt.ben   = '0;
						// Place master lanes at their offset within the slave word
						off = slave_off(req_i.addr);
						for (int i = 0; i < 8; i++) begin
							st_nxt.bytes[i + int'(off)] = val[i*8 +: 8];
							st_nxt.ben[i + int'(off)]   = m[i];
						end
						st_nxt.addr  = (SB < 4) ? (req_i.addr & ~mbw_pkg::AW'(3)) : base;
						// Beats to cover the touched span
						st_nxt.left  = span_beats(req_i.size, off);
						st_nxt.state = mbw_pkg::MBW_BEAT;
					end
				end
			end
			mbw_pkg::MBW_BEAT: begin
				// Lowest slave-width slice goes out first
				beat_in.addr = st_r.addr;
				beat_in.data = SLV_W'(st_r.bytes);
				beat_in.be   = SB'(st_r.ben);
				// Empty slices advance without a slave beat
				pick = buf_in_ready || !beat_live;
				if (pick) begin
					st_nxt.bytes = st_r.bytes >> SLV_W;
					st_nxt.ben   = st_r.ben >> SB;
					st_nxt.addr  = st_r.addr + mbw_pkg::AW'(SB);
					st_nxt.left  = st_r.left - 5'h1;
					if (st_r.left == 5'h1) begin
						st_nxt.state = mbw_pkg::MBW_IDLE;
					end
				end
			end
			default: st_nxt.state = mbw_pkg::MBW_IDLE;
		endcase
		// Output stage registers the buffer head
		st_nxt.wr = buf_out_valid;
		st_nxt.oaddr = beat_out.addr;
		st_nxt.odata = lane_data;
		st_nxt.obe   = buf_out_valid ? beat_out.be : '0;
		if (st_r.wr && slv_wait_i) begin
			st_nxt.wr    = st_r.wr;
			st_nxt.oaddr = st_r.oaddr;
			st_nxt.odata = st_r.odata;
			st_nxt.obe   = st_r.obe;
		end
		st_nxt.rdy = (st_nxt.state == mbw_pkg::MBW_IDLE);
	end

	// Pop when the output stage can take a new beat
	assign buf_pop = ~(st_r.wr && slv_wait_i);

	// A slice with no enabled lane is dropped rather than written
	assign beat_live = (st_r.state == mbw_pkg::MBW_BEAT) && (SB'(st_r.ben) != '0);

	// Disabled lanes of a written beat leave the port at zero, never a stale byte
	for (genvar g = 0; g < SB; g++) begin : g_lane
		assign lane_data[g*8 +: 8] = beat_out.be[g] ? beat_out.data[g*8 +: 8] : 8'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// Two-entry buffer between beat generator and slave port

	mbw_skid #(
		.W (BW)
	) u_skid (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.in_valid_i  (beat_live),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (beat_in),
		.out_valid_o (buf_out_valid),
		.out_ready_i (buf_pop),
		.out_data_o  (beat_out)
	);

	////////////////////////////////////////////////////////////////////////
	// State register and outputs

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= ST_RST;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	// lanes already little-endian, no byte swap applied
	assign slv_write_o    = st_r.wr;
	assign slv_addr_o     = st_r.oaddr;
	assign slv_wdata_o    = st_r.odata;
	assign slv_be_o       = st_r.obe;
	assign req_misalign_o = st_r.misalign;
endmodule

// ===== mbw_adapter_sva.sv
// Port assertions for the width adapter
`timescale 1ns/1ps
module mbw_chk #(
	parameter int SLV_W = 16
) (
	// Watched ports
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire logic                   req_valid_i,
	input wire logic                   req_ready_o,
	input wire mbw_pkg::mbw_req_s      req_i,
	input wire logic                   req_misalign_o,
	input wire logic                   slv_write_o,
	input wire logic [mbw_pkg::AW-1:0] slv_addr_o,
	input wire logic [SLV_W-1:0]       slv_wdata_o,
	input wire logic [SLV_W/8-1:0]     slv_be_o,
	input wire logic                   slv_wait_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic       bad;
	logic [5:0] busy_r;
	assign bad = (req_i.size == mbw_pkg::SZ_HALF && req_i.addr[0]) ||
		(req_i.size >= mbw_pkg::SZ_WORD && req_i.addr[1:0] != 2'h0);
	sequence s_take; req_valid_i && req_ready_o; endsequence
	sequence s_stall; slv_write_o && slv_wait_i; endsequence
	// Cycles spent not ready
	always_ff @(posedge clk_i) begin
		busy_r <= (rst_i || req_ready_o) ? 6'h0 : busy_r + 6'h1;
	end
	AST_HOLD: assert property (s_stall |=> slv_write_o && $stable(slv_addr_o) &&
		$stable(slv_be_o) && $stable(slv_wdata_o)) else $error("beat changed under wait");
	AST_BE: assert property (slv_write_o |-> slv_be_o != '0)
		else $error("beat without enables");
	AST_ALIGN: assert property (slv_write_o |-> slv_addr_o % (SLV_W/8) == 0)
		else $error("beat address not lane aligned");
	AST_BAD: assert property (s_take ##0 bad |=> req_misalign_o)
		else $error("misaligned request not flagged");
	AST_GOOD: assert property (s_take ##0 !bad |=> !req_misalign_o)
		else $error("aligned request flagged");
	AST_LAT: assert property (s_take ##0 !bad |-> ##[1:16] slv_write_o)
		else $error("no beat after request");
	AST_RST: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
		req_ready_o && !slv_write_o) else $error("beat pending after reset");
	AST_BUSY: assert property (busy_r < 6'h28)
		else $error("request side stuck");
endmodule

// ===== mbw_adapter_tb.sv
// Self-checking bench for the width adapter
`timescale 1ns/1ps
module mbw_adapter_tb;
	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic              req_valid_i = 1'b0;
	logic              slow = 1'b0;
	logic              ce = 1'b1;
	mbw_pkg::mbw_req_s req_i = '0;
	logic              req_ready_o;
	logic              req_misalign_o;
	logic              slv_write_o;
	logic [31:0]       slv_addr_o;
	logic [15:0]       slv_wdata_o;
	logic [1:0]        slv_be_o;
	logic              slv_wait_i;
	int                mismatches = 0;
	int                checks = 0;
	int                cyc = 0;
	int                nb = 0;
	always #50 clk_i = ~clk_i;
	mbw_adapter #(.SLV_W(16)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
		.req_misalign_o(req_misalign_o), .slv_write_o(slv_write_o), .slv_addr_o(slv_addr_o),
		.slv_wdata_o(slv_wdata_o), .slv_be_o(slv_be_o), .slv_wait_i(slv_wait_i));
	mbw_slave_model SLV (.clk_i(clk_i), .write_i(slv_write_o), .addr_i(slv_addr_o),
		.wdata_i(slv_wdata_o), .be_i(slv_be_o), .wait_o(slv_wait_i), .slow_i(slow));
	////////////////////////////////////////////////////////////////
	task print_verdict;
		$display("mismatches=%0d checks=%0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Request held until taken, then waits for n more beats
	task send(input logic [1:0] sz, input logic [31:0] a, input logic [63:0] d, input int n);
		req_valid_i = 1'b1;
		req_i = '{sz, a, d};
		while (req_ready_o !== 1'b1) @(negedge clk_i);
		@(negedge clk_i);
		req_valid_i = 1'b0;
		nb += n;
		@(negedge clk_i);
		for (int k = 0; k < 40 && SLV.beats != nb; k++) @(negedge clk_i);
		chk(SLV.beats, nb);
	endtask
	task t_bytes;
		for (int i = 0; i < 4; i++) send(mbw_pkg::SZ_BYTE, 32'h4 + i, 64'h0a + i, 1);
		chk({SLV.mem[7], SLV.mem[6], SLV.mem[5], SLV.mem[4]}, 32'h0d0c0b0a);
		chk(SLV.mem[3], 32'hee);
	endtask
	task t_halves;
		send(mbw_pkg::SZ_HALF, 32'h8, 64'h0a0b, 1);
		send(mbw_pkg::SZ_HALF, 32'ha, 64'h0c0d, 1);
		chk({SLV.mem[11], SLV.mem[10], SLV.mem[9], SLV.mem[8]}, 32'h0c0d0a0b);
	endtask
	task t_wide;
		slow = 1'b1;
		send(mbw_pkg::SZ_WORD, 32'h10, 64'h0a0b0c0d, 2);
		chk({SLV.mem[19], SLV.mem[18], SLV.mem[17], SLV.mem[16]}, 32'h0a0b0c0d);
		chk(SLV.last_a, 32'h12);
		chk(SLV.mem[16], 32'h0d);
		send(mbw_pkg::SZ_DWRD, 32'h18, 64'h0807060504030201, 4);
		slow = 1'b0;
		chk({SLV.mem[27], SLV.mem[26], SLV.mem[25], SLV.mem[24]}, 32'h04030201);
		chk({SLV.mem[31], SLV.mem[30], SLV.mem[29], SLV.mem[28]}, 32'h08070605);
		chk(SLV.mem[24], 32'h01);
		chk(SLV.last_a, 32'h1e);
	endtask
	task t_bad;
		send(mbw_pkg::SZ_HALF, 32'h21, 64'hffff, 0);
		chk(req_misalign_o, 32'h1);
		send(mbw_pkg::SZ_WORD, 32'h22, 64'hffff, 0);
		chk(req_misalign_o, 32'h1);
		send(mbw_pkg::SZ_BYTE, 32'h23, 64'h55, 1);
		chk(req_misalign_o, 32'h0);
		chk({SLV.mem[35], SLV.mem[34], SLV.mem[33], SLV.mem[32]}, 32'h55eeeeee);
	endtask
	// Enable low stalls a taken word; it completes once enable returns
	task t_freeze;
		req_valid_i = 1'b1;
		req_i = '{mbw_pkg::SZ_WORD, 32'h24, 64'h11223344};
		@(negedge clk_i);
		req_valid_i = 1'b0;
		ce = 1'b0;
		repeat (6) @(negedge clk_i);
		chk(SLV.beats, nb);
		chk(req_ready_o, 32'h0);
		ce = 1'b1;
		nb += 2;
		for (int k = 0; k < 40 && SLV.beats != nb; k++) @(negedge clk_i);
		chk(SLV.beats, nb);
		chk({SLV.mem[39], SLV.mem[38], SLV.mem[37], SLV.mem[36]}, 32'h11223344);
	endtask
	// Reset in mid-transfer drops every pending beat
	task t_reset;
		req_valid_i = 1'b1;
		req_i = '{mbw_pkg::SZ_DWRD, 32'h28, 64'h0102030405060708};
		@(negedge clk_i);
		req_valid_i = 1'b0;
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		chk(req_ready_o, 32'h1);
		chk(slv_write_o, 32'h0);
		repeat (10) @(negedge clk_i);
		chk(SLV.beats, nb);
		chk(SLV.mem[40], 32'hee);
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			print_verdict;
		end
	end
	initial begin
		repeat (20) @(negedge clk_i);
		rst_i = 1'b0;
		t_bytes;
		t_halves;
		t_wide;
		t_bad;
		t_freeze;
		t_reset;
		print_verdict;
	end
endmodule
bind mbw_adapter mbw_chk #(.SLV_W(SLV_W)) CHK (.clk_i(clk_i), .rst_i(rst_i),
	.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
	.req_misalign_o(req_misalign_o), .slv_write_o(slv_write_o), .slv_addr_o(slv_addr_o),
	.slv_wdata_o(slv_wdata_o), .slv_be_o(slv_be_o), .slv_wait_i(slv_wait_i));

// ===== mbw_pkg.sv
// Shared types and constants for the byte-lane width adapter
package mbw_pkg;
	localparam int MST_W      = 32;
	localparam int MST_BYTES  = 4;
	localparam int BYTE_W     = 8;
	localparam int AW         = 32;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_DWRD = 2'h3;
	localparam logic [3:0] BE_HALF = 4'h3;
	localparam logic [3:0] BE_WORD = 4'hf;
	localparam logic [3:0] BE_NONE = 4'h0;
	localparam logic [AW-1:0] WORD_STEP = 32'h4;

	// Master request: size code, byte address, up to 64 bits of value
	typedef struct packed {
		logic [1:0]    size;
		logic [AW-1:0] addr;
		logic [63:0]   data;
	} mbw_req_s;

	typedef enum logic [1:0] {
		MBW_IDLE = 2'b00,
		MBW_BEAT = 2'b01
	} mbw_state_e;
endpackage

// ===== mbw_skid.sv
// Two-entry valid/ready buffer in the slave-side beat path
`timescale 1ns/1ps
module mbw_skid #(
	parameter int W = 8
) (
	// Clock, reset and enable
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	// Fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// Drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic [1:0]        cnt;
		logic              rd;
		logic              wr;
	} mbw_skid_s;

	mbw_skid_s st_r;
	mbw_skid_s st_nxt;
	logic      push;
	logic      pop;

	assign in_ready_o  = (st_r.cnt != 2'h2);
	assign out_valid_o = (st_r.cnt != 2'h0);
	assign out_data_o  = st_r.mem[st_r.rd];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wr] = in_data_i;
			st_nxt.wr           = ~st_r.wr;
		end
		if (pop) begin
			st_nxt.rd = ~st_r.rd;
		end
		st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end
endmodule

// ===== mbw_slave_model.sv
// Byte memory slave with optional wait states
`timescale 1ns/1ps
module mbw_slave_model (
	// Clock
	input  wire logic        clk_i,
	// Slave port
	input  wire logic        write_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [1:0]  be_i,
	output logic             wait_o,
	// Control
	input  wire logic        slow_i
);
	logic [7:0]  mem [0:63];
	logic [31:0] last_a;
	int          beats;
	logic        tog;
	initial begin
		tog = 1'b0;
		beats = 0;
		last_a = '0;
		for (int i = 0; i < 64; i++) mem[i] = 8'hee;
	end
	assign wait_o = slow_i & ~tog;
	always @(posedge clk_i) begin
		tog <= ~tog;
		if (write_i && !wait_o) begin
			beats <= beats + 1;
			last_a <= addr_i;
			if (be_i[0]) mem[{addr_i[5:1], 1'b0}] <= wdata_i[7:0];
			if (be_i[1]) mem[{addr_i[5:1], 1'b1}] <= wdata_i[15:8];
		end
	end
endmodule
